// ===== bench/ssm_checker.sv
// checker for the serial memory command logic
// assumes it is bound to ssm_top
`timescale 1ns/1ps
module ssm_checker
   import ssm_pkg::*;
#(parameter int DEPTH = 32) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic hold_n,
   input wire logic so,
   input wire logic so_oe_n,
   input wire logic wr_valid,
   input wire logic wr_ready,
   input wire logic [ssm_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] status_byte
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_hold_float; (!hold_n && !cs_n) [*6] |-> so_oe_n; endproperty
   a_hold_float: assert property (p_hold_float) else $error("output driven in hold");
   property p_desel_float; cs_n [*6] |-> so_oe_n; endproperty
   a_desel_float: assert property (p_desel_float) else $error("output driven while deselected");
   property p_so_stable; (sck && !cs_n && hold_n) [*4] |-> $stable(so); endproperty
   a_so_stable: assert property (p_so_stable) else $error("output moved while clock high");
   property p_wr_hold; wr_valid && !wr_ready |=> wr_valid && $stable(wr_addr) && $stable(wr_data); endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write stream dropped");
   property p_bits; status_byte[0] == 1'b0 && status_byte[6:4] == 3'h0; endproperty
   a_bits: assert property (p_bits) else $error("fixed status bits wrong");
   property p_rst_latch; $past(rst) |-> status_byte[1] == 1'b0; endproperty
   a_rst_latch: assert property (p_rst_latch) else $error("latch set after reset");
   property p_sr_gate; $changed(status_byte[7:2]) |-> $past(status_byte[1]); endproperty
   a_sr_gate: assert property (p_sr_gate) else $error("status written without latch");
   property p_wr_gate; $rose(wr_valid) |-> $past(status_byte[1]) || $past(status_byte[1], 2); endproperty
   a_wr_gate: assert property (p_wr_gate) else $error("array write without latch");
endmodule

bind ssm_top ssm_checker #(.DEPTH(DEPTH)) u_ssm_checker (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck),
   .hold_n(hold_n), .so(so), .so_oe_n(so_oe_n), .wr_valid(wr_valid), .wr_ready(wr_ready),
   .wr_addr(wr_addr), .wr_data(wr_data), .status_byte(status_byte));

// ===== bench/ssm_mst.sv
// spi master model, mode 0, sck period eight clk cycles
// assumes a 125 MHz clk
`timescale 1ns/1ps
module ssm_mst (
   input wire logic clk,
   input wire logic so,
   output logic cs_n,
   output logic sck,
   output logic si,
   output logic hold_n
);
   logic [7:0] rxb [0:39];
   initial begin
      cs_n = 1'b1;
      sck = 1'b0;
      si = 1'b0;
      hold_n = 1'b1;
   end
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   // n bits: nb bytes of v, then zeros; pause before bit hp
   task automatic frame(input logic [47:0] v, input int nb, input int n, input int hp);
      cs_n <= 1'b0;
      half();
      for (int b = 0; b < n; b++) begin
         si <= (b < 8 * nb) ? v[8 * nb - 1 - b] : 1'b0;
         half();
         if (b == hp) begin
            hold_n <= 1'b0;
            half();
            sck <= 1'b1;
            half();
            sck <= 1'b0;
            half();
            hold_n <= 1'b1;
            half();
         end
         sck <= 1'b1;
         repeat (2) @(posedge clk);
         rxb[b / 8][7 - b % 8] = so;
         repeat (2) @(posedge clk);
         sck <= 1'b0;
      end
      half();
      cs_n <= 1'b1;
      si <= ~si;
      half();
      half();
   endtask
endmodule

// ===== bench/testbench.sv
// self-checking bench for the serial memory command logic
// assumes ssm_top, ssm_mst and the bound checker
`timescale 1ns/1ps
module testbench;
   import ssm_pkg::*;
   logic clk, rst, wp_n, wr_ready, cs_n, sck, si, hold_n, so, so_oe_n, wr_valid;
   logic [ADDR_W-1:0] wr_addr, rd_addr;
   logic [7:0] wr_data, rd_data, status_byte;
   logic [21:0] wq [$];
   int error_cnt, checks_done;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   assign rd_data = ~rd_addr[7:0];
   always @(posedge clk) begin
      if (wr_valid && wr_ready) begin
         wq.push_back({wr_addr, wr_data});
      end
   end
   ssm_top u_ssm_top (.clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .hold_n(hold_n),
      .so(so), .so_oe_n(so_oe_n), .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
      .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data), .status_byte(status_byte));
   ssm_mst u_ssm_mst (.clk(clk), .so(so), .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic f(input logic [47:0] v, input int nb, input int n);
      u_ssm_mst.frame(v, nb, n, -1);
   endtask
   task automatic wrap_up();
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      wrap_up();
   end
   initial begin
      rst = 1'b1;
      wp_n = 1'b1;
      wr_ready = 1'b1;
      error_cnt = 0;
      checks_done = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(status_byte, 8'h00);
      f(48'h06, 1, 5);
      chk(status_byte, 8'h00);
      f(48'h06, 1, 8);
      chk(status_byte, 8'h02);
      f(48'h04, 1, 8);
      f(48'h01FF, 2, 16);
      chk(status_byte, 8'h00);
      f(48'h06, 1, 8);
      f(48'h01FF, 2, 16);
      chk(status_byte, 8'h8C);
      u_ssm_mst.frame(48'h05, 1, 24, 12);
      chk({u_ssm_mst.rxb[1], u_ssm_mst.rxb[2]}, 16'h8C8C);
      wp_n <= 1'b0;
      f(48'h06, 1, 8);
      f(48'h0100, 2, 16);
      chk(status_byte, 8'h8C);
      wp_n <= 1'b1;
      f(48'h06, 1, 8);
      f(48'h0100, 2, 16);
      chk(status_byte, 8'h00);
      wq.delete();
      f(48'h06, 1, 8);
      f(48'h02FFFFAABB, 5, 40);
      f(48'h02000033, 4, 32);
      chk(wq.size(), 2);
      chk(wq[0], {14'h3FFF, 8'hAA});
      chk(wq[1], {14'h0000, 8'hBB});
      for (int g = 0; g < 4; g++) begin
         wq.delete();
         f(48'h06, 1, 8);
         f(48'h0100 | 48'(g * 4), 2, 16);
         f(48'h06, 1, 8);
         f(48'h022FFF5566, 5, 40);
         f(48'h06, 1, 8);
         f(48'h021FFF7788, 5, 40);
         chk(wq.size(), 32'(4 - g - int'(g > 1)));
      end
      f(48'h06, 1, 8);
      f(48'h06, 1, 8);
      f(48'h0100, 2, 16);
      wq.delete();
      wr_ready <= 1'b0;
      f(48'h06, 1, 8);
      f(48'h020100, 3, 296);
      wr_ready <= 1'b1;
      repeat (40) @(posedge clk);
      chk(wq.size(), 32);
      chk(wq[31], {14'h011F, 8'h00});
      f(48'h03FFFF, 3, 40);
      chk({u_ssm_mst.rxb[3], u_ssm_mst.rxb[4]}, 16'h00FF);
      f(48'h0B001000, 4, 48);
      chk({u_ssm_mst.rxb[4], u_ssm_mst.rxb[5]}, 16'hEFEE);
      f(48'h9F, 1, 48);
      chk({u_ssm_mst.rxb[1], u_ssm_mst.rxb[2], u_ssm_mst.rxb[3], u_ssm_mst.rxb[4]}, IDENTITY_WORD);
      chk(u_ssm_mst.rxb[5], {8{IDENTITY_WORD[0]}});
      f(48'h06, 1, 8);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      chk(status_byte, 8'h00);
      wrap_up();
   end
endmodule

// ===== rtl/ssm_pkg.sv
// constants for the serial memory command logic
// assumes a single system clock; serial pins are asynchronous to it
package ssm_pkg;
   localparam logic [7:0] SET_WRITE_LATCH_CMD = 8'h06;
   localparam logic [7:0] CLEAR_WRITE_LATCH_CMD = 8'h04;
   localparam logic [7:0] STATUS_READ_CMD = 8'h05;
   localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
   localparam logic [7:0] ARRAY_WRITE_CMD = 8'h02;
   localparam logic [7:0] IDENTITY_READ_CMD = 8'h9F;
   localparam logic [7:0] FAST_ARRAY_READ_CMD = 8'h0B;
   localparam int ADDR_W = 14;
   localparam logic [13:0] QUARTER_BASE = 14'h3000;
   localparam logic [13:0] HALF_BASE = 14'h2000;
   localparam logic [4:0] STATUS_NV_RESET = 5'h00;
   localparam logic [2:0] OPC_LAST_BIT = 3'h7;
   localparam logic [4:0] ADDR_LAST_BIT = 5'h0F;
   localparam logic [4:0] ID_LAST_BIT = 5'h1F;
   // identity values are arbitrary
   localparam logic [31:0] IDENTITY_WORD = 32'h5A01A55A;
   localparam int FIFO_DEPTH = 32;
   typedef enum logic [2:0] {SSM_OPC, SSM_ADDR, SSM_DUMMY, SSM_RD, SSM_WR, SSM_SR_RD, SSM_SR_WR, SSM_ID}
      ssm_state_t;
endpackage

// ===== rtl/ssm_top.sv
// serial memory command logic with fifo of written bytes
// assumes serial pins are asynchronous and sampled by clk
`timescale 1ns/1ps

module ssm_fifo #(parameter int WIDTH = 22, parameter int DEPTH = 32) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp, rp, next_wp, next_rp;
   always_comb begin
      next_wp = wp;
      next_rp = rp;
      if (in_valid && in_ready) begin
         next_wp = wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         next_rp = rp + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wp <= '0;
         rp <= '0;
      end else begin
         wp <= next_wp;
         rp <= next_rp;
      end
   end
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wp[AW-1:0]] <= in_data;
      end
   end
   assign in_ready = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
   assign out_valid = (wp != rp);
   assign out_data = mem[rp[AW-1:0]];
endmodule

// Functional notes
// - command starts with eight opcode bits
// - early deselect discards partial opcode
// - set command sets write latch
// - clear command clears latch; writes refused
// - status read shifts eight status bits
// - status byte repeats while clocking
// - status write stores bits 7, 3 and 2 if allowed
// - latch bit and bit zero ignored
// - array read outputs addressed byte
// - reads increment and wrap forever
// - array write stores each full byte; dropped if fifo full
// - writes increment, wrap, end on deselect
// - fast read takes dummy byte then reads
// - identity read outputs thirty-two bits
// - last identity bit held afterwards
// - guard bits select protected range
// - latch and guards gate array writes; latch and pin gate status writes
// - hold pauses command, floats array and status read output
// - deselect in hold aborts command
// - latch cleared at reset, clear, after writes
// - sample rising edge, drive falling edge
// - status byte bit layout
module ssm_top
   import ssm_pkg::*;
#(parameter int DEPTH = ssm_pkg::FIFO_DEPTH) (
   input wire logic clk,
   input wire logic rst,
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic wp_n,
   input wire logic hold_n,
   output logic so,
   output logic so_oe_n,
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [ssm_pkg::ADDR_W-1:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [ssm_pkg::ADDR_W-1:0] rd_addr,
   input wire logic [7:0] rd_data,
   output logic [7:0] status_byte
);
   import ssm_pkg::*;
   // pin synchroniser, two stages
   logic [4:0] s1, s2;
   logic sck_d;
   always_ff @(posedge clk) begin
      if (rst) begin
         s1 <= 5'h1F;
         s2 <= 5'h1F;
         sck_d <= 1'b0;
      end else begin
         s1 <= {cs_n, sck, si, wp_n, hold_n};
         s2 <= s1;
         sck_d <= s2[3];
      end
   end

   logic cs_q, sck_q, si_q, wp_q, hold_q;
   assign {cs_q, sck_q, si_q, wp_q, hold_q} = s2;

   logic active, rise, fall;
   assign active = !cs_q && hold_q;
   assign rise = active && sck_q && !sck_d;
   assign fall = active && !sck_q && sck_d;

   ssm_state_t st, next_st;
   logic [7:0] sh, next_sh;
   logic [4:0] cnt, next_cnt;
   logic [7:0] opc, next_opc;
   logic [13:0] addr, next_addr;
   logic [7:0] obuf, next_obuf;
   logic [4:0] nv, next_nv;
   logic write_enable_latch, next_wel, wrcmd, next_wrcmd;
   logic sel, next_sel, so_r, next_so, oe_n, next_oe_n;
   logic f_valid, f_ready;
   logic [21:0] f_in;
   logic guarded, sr_prot;

   // guard range and protection
   always_comb begin
      unique case (nv[1:0])
         2'b00: begin
            guarded = 1'b0;
         end
         2'b01: begin
            guarded = addr >= QUARTER_BASE;
         end
         2'b10: begin
            guarded = addr >= HALF_BASE;
         end
         default: begin
            guarded = 1'b1;
         end
      endcase
   end

   assign sr_prot = !write_enable_latch || (nv[4] && !wp_q);

   // status byte layout, unused bits read zero
   always_comb begin
      status_byte = 8'h00;
      status_byte[7] = nv[4];
      status_byte[3:2] = nv[1:0];
      status_byte[1] = write_enable_latch;
   end

   // next state and datapath

   always_comb begin
      next_st = st;
      next_sh = sh;
      next_cnt = cnt;
      next_opc = opc;
      next_addr = addr;
      next_obuf = obuf;
      next_nv = nv;
      next_wel = write_enable_latch;
      next_wrcmd = wrcmd;
      next_sel = !cs_q;
      next_so = so_r;
      next_oe_n = oe_n;
      f_valid = 1'b0;
      if (cs_q) begin
         // deselect: partial opcode dropped, latch cleared after writes
         next_st = SSM_OPC;
         next_cnt = 5'h00;
         next_oe_n = 1'b1;
         if (sel && wrcmd) begin
            next_wel = 1'b0;
         end
         next_wrcmd = 1'b0;
      end else if (!hold_q) begin
         if (st == SSM_RD || st == SSM_SR_RD) begin
            next_oe_n = 1'b1;
         end
      end else begin
         if (st == SSM_RD || st == SSM_SR_RD || st == SSM_ID) begin
            next_oe_n = 1'b0;
         end
         if (rise) begin
            next_sh = {sh[6:0], si_q};
            next_cnt = cnt + 5'h01;
            unique case (st)
               SSM_OPC: begin
                  if (cnt[2:0] == OPC_LAST_BIT) begin
                     next_opc = {sh[6:0], si_q};
                     next_cnt = 5'h00;
                     unique case ({sh[6:0], si_q})
                        SET_WRITE_LATCH_CMD: next_wel = 1'b1;
                        CLEAR_WRITE_LATCH_CMD: next_wel = 1'b0;
                        STATUS_READ_CMD: begin
                           next_st = SSM_SR_RD;
                           next_obuf = status_byte;
                        end
                        STATUS_WRITE_CMD: begin
                           next_st = SSM_SR_WR;
                           next_wrcmd = 1'b1;
                        end
                        ARRAY_READ_CMD, FAST_ARRAY_READ_CMD: next_st = SSM_ADDR;
                        ARRAY_WRITE_CMD: begin
                           next_st = SSM_ADDR;
                           next_wrcmd = 1'b1;
                        end
                        IDENTITY_READ_CMD: next_st = SSM_ID;
                        default: next_st = SSM_DUMMY;
                     endcase
                  end
               end
               SSM_ADDR: begin
                  next_addr = {addr[12:0], si_q};
                  if (cnt == ADDR_LAST_BIT) begin
                     next_cnt = 5'h00;
                     if (opc == ARRAY_WRITE_CMD) begin
                        next_st = SSM_WR;
                        next_wrcmd = 1'b1;
                     end else if (opc == FAST_ARRAY_READ_CMD) begin
                        next_st = SSM_DUMMY;
                     end else begin
                        next_st = SSM_RD;
                        next_obuf = rd_data;
                     end
                  end
               end
               SSM_DUMMY: begin
                  if (opc == FAST_ARRAY_READ_CMD && cnt[2:0] == OPC_LAST_BIT) begin
                     next_st = SSM_RD;
                     next_cnt = 5'h00;
                     next_obuf = rd_data;
                  end
               end
               SSM_RD: begin
                  if (cnt[2:0] == OPC_LAST_BIT) begin
                     next_cnt = 5'h00;
                     next_addr = addr + 14'h0001;
                  end
               end
               SSM_SR_RD: begin
                  if (cnt[2:0] == OPC_LAST_BIT) begin
                     next_cnt = 5'h00;
                     next_obuf = status_byte;
                  end
               end
               SSM_SR_WR: begin
                  if (cnt[2:0] == OPC_LAST_BIT) begin
                     next_st = SSM_DUMMY;
                     if (!sr_prot) begin
                        // bit 7 and guard bits kept; latch and bit zero dropped
                        next_nv = {sh[6], 2'b00, sh[2:1]};
                     end
                  end
               end
               SSM_WR: begin
                  if (cnt[2:0] == OPC_LAST_BIT) begin
                     next_cnt = 5'h00;
                     f_valid = write_enable_latch && !guarded && f_ready;
                     next_addr = addr + 14'h0001;
                  end
               end
               SSM_ID: begin
                  if (cnt == ID_LAST_BIT) begin
                     next_cnt = ID_LAST_BIT;
                  end
               end
               default: next_st = SSM_OPC;
            endcase
         end

         if (fall) begin
            unique case (st)
               SSM_RD, SSM_SR_RD: begin
                  next_so = obuf[7];
                  next_obuf = {obuf[6:0], 1'b0};
                  if (cnt[2:0] == 3'h0 && st == SSM_RD) begin
                     next_so = rd_data[7];
                     next_obuf = {rd_data[6:0], 1'b0};
                  end
               end
               SSM_ID: begin
                  // msb first; last bit held once cnt saturates
                  next_so = IDENTITY_WORD[5'h1F - cnt];
               end
               default: next_so = so_r;
            endcase
         end
      end
   end

   // registers
   always_ff @(posedge clk) begin
      if (rst) begin
         st <= SSM_OPC;
         sh <= 8'h00;
         cnt <= 5'h00;
         opc <= 8'h00;
         addr <= 14'h0000;
         obuf <= 8'h00;
         nv <= STATUS_NV_RESET;
         write_enable_latch <= 1'b0;
         wrcmd <= 1'b0;
         sel <= 1'b0;
         so_r <= 1'b0;
         oe_n <= 1'b1;
      end else begin
         st <= next_st;
         sh <= next_sh;
         cnt <= next_cnt;
         opc <= next_opc;
         addr <= next_addr;
         obuf <= next_obuf;
         nv <= next_nv;
         write_enable_latch <= next_wel;
         wrcmd <= next_wrcmd;
         sel <= next_sel;
         so_r <= next_so;
         oe_n <= next_oe_n;
      end
   end

   assign f_in = {addr, sh[6:0], si_q};
   assign rd_addr = addr;
   assign so = so_r;
   assign so_oe_n = oe_n;

   // write stream buffer

   ssm_fifo #(.WIDTH(22), .DEPTH(DEPTH)) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(f_valid),
      .in_ready(f_ready),
      .in_data(f_in),
      .out_valid(wr_valid),
      .out_ready(wr_ready),
      .out_data({wr_addr, wr_data})
   );
endmodule
